// >>> logic/gvfr_pkg.sv
// constants and carrier types for the vertical/field reference input stage
package gvfr_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    // shortest level accepted on the vertical/field pins (least time, rounds up)
    localparam int FILTER_NS = 20;
    localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W = 3;
    localparam logic [FILT_W-1:0] FILTER_LAST = FILT_W'(FILTER_CYCLES - 1);

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int NUM_REFS = 2;
    localparam int REF_VERT = 0;
    localparam int REF_FIELD = 1;
    // a frame at 24 Hz is about 10.4M cycles at 250 MHz
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
    localparam logic LEVEL_RST = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        POL_WAIT,
        POL_PART,
        POL_ONE,
        POL_LOCK
    } gvfr_pol_state_type;

    typedef struct packed {
        logic vertLead;
        logic polarityLow;
        logic polarityValid;
    } gvfr_vert_ref_type;

    typedef struct packed {
        logic vertScanRef;
        logic fieldStart;
        logic firstField;
        logic fieldValid;
    } gvfr_lock_ref_type;

    localparam gvfr_vert_ref_type VERT_REF_RST = 3'h0;
    localparam gvfr_lock_ref_type LOCK_REF_RST = 4'h0;

endpackage

// >>> logic/gvfr_sync3.sv
// three-stage synchroniser with agreement check for asynchronous reference pins
`timescale 1ns/1ns
`default_nettype none
module gvfr_sync3 (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [gvfr_pkg::NUM_REFS-1:0] asyncIn,
    output logic [gvfr_pkg::NUM_REFS-1:0] stable
);

    // ------------------------------------------------------------
    // per-pin chain
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < gvfr_pkg::NUM_REFS; i++) begin : g_pin
            logic s1;
            logic s2;
            logic s3;

            // s1 only feeds s2, to keep metastability off the logic
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1 <= gvfr_pkg::LEVEL_RST;
                    s2 <= gvfr_pkg::LEVEL_RST;
                    s3 <= gvfr_pkg::LEVEL_RST;
                end else begin
                    s1 <= asyncIn[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end

            // change accepted once the last two stages agree
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    stable[i] <= gvfr_pkg::LEVEL_RST;
                end else if (s2 == s3) begin
                    stable[i] <= s3;
                end
            end

            AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (sys_rst)
                    $changed(stable[i]) |-> $past(s2) == $past(s3))
                else $error("synchroniser output changed without stage agreement");
        end
    endgenerate

endmodule // gvfr_sync3
`default_nettype wire

// >>> logic/gvfr_ref_input.sv
// vertical and field reference input stage of the genlock timing generator
//
// What this block does
// - in genlock, sense vertical reference polarity and lock to its leading edge.
// - in preset format mode, vertical reference drives the vertical scanning lock.
// - accept loose analog or clean digital edges on the reference pins.
// - first field is the one whose first broad pulse is in line's first half.
// - in preset format mode, field pin drives the odd/even lock reference.
`timescale 1ns/1ns
`default_nettype none
module gvfr_ref_input (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic vertRefIn,
    input wire logic fieldReferenceIn,
    input wire logic genlockEn,
    input wire logic presetModeEn,
    input wire logic fieldConvBlanking,
    input wire logic fieldPresent,
    output gvfr_pkg::gvfr_vert_ref_type vertRef,
    output gvfr_pkg::gvfr_lock_ref_type lockRef
);

    // ------------------------------------------------------------
    // synchronise and filter
    // ------------------------------------------------------------
    logic [gvfr_pkg::NUM_REFS-1:0] syncLevel;
    logic [gvfr_pkg::NUM_REFS-1:0] filt;

    gvfr_sync3 gvfr_sync3_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({fieldReferenceIn, vertRefIn}),
        .stable(syncLevel)
    );

    // analog-derived edges may ring; a level must hold before it counts
    genvar i;
    generate
        for (i = 0; i < gvfr_pkg::NUM_REFS; i++) begin : g_filt
            logic [gvfr_pkg::FILT_W-1:0] filtCnt;

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    filtCnt <= '0;
                    filt[i] <= gvfr_pkg::LEVEL_RST;
                end else if (syncLevel[i] != filt[i]) begin
                    if (filtCnt == gvfr_pkg::FILTER_LAST) begin
                        filtCnt <= '0;
                        filt[i] <= syncLevel[i];
                    end else begin
                        filtCnt <= filtCnt + 1'b1;
                    end
                end else begin
                    filtCnt <= '0;
                end
            end
        end
    endgenerate

    wire logic vFilt = filt[gvfr_pkg::REF_VERT];
    wire logic fFilt = filt[gvfr_pkg::REF_FIELD];

    // ------------------------------------------------------------
    // edges and phase lengths
    // ------------------------------------------------------------
    logic vPrev;
    logic [gvfr_pkg::CNT_W-1:0] highCnt;
    logic [gvfr_pkg::CNT_W-1:0] lowCnt;
    logic [gvfr_pkg::CNT_W-1:0] highLen;
    logic [gvfr_pkg::CNT_W-1:0] lowLen;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vPrev <= gvfr_pkg::LEVEL_RST;
        end else begin
            vPrev <= vFilt;
        end
    end

    wire logic vRise = vFilt & ~vPrev;
    wire logic vFall = ~vFilt & vPrev;
    wire logic vEdge = vRise | vFall;

    // counters saturate so a stalled reference never wraps into a false period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            highCnt <= gvfr_pkg::CNT_RST;
            lowCnt <= gvfr_pkg::CNT_RST;
            highLen <= gvfr_pkg::CNT_RST;
            lowLen <= gvfr_pkg::CNT_RST;
        end else begin
            if (vFall) begin
                highLen <= highCnt;
                highCnt <= gvfr_pkg::CNT_RST;
            end else if (vFilt && highCnt != gvfr_pkg::CNT_MAX) begin
                highCnt <= highCnt + 1'b1;
            end
            if (vRise) begin
                lowLen <= lowCnt;
                lowCnt <= gvfr_pkg::CNT_RST;
            end else if (!vFilt && lowCnt != gvfr_pkg::CNT_MAX) begin
                lowCnt <= lowCnt + 1'b1;
            end
        end
    end

    wire logic [gvfr_pkg::CNT_W-1:0] next_highLen = vFall ? highCnt : highLen;
    wire logic [gvfr_pkg::CNT_W-1:0] next_lowLen = vRise ? lowCnt : lowLen;

    // ------------------------------------------------------------
    // polarity detection
    // ------------------------------------------------------------
    // the first edge ends a phase of unknown start, so two more are needed
    gvfr_pkg::gvfr_pol_state_type polState;
    gvfr_pkg::gvfr_pol_state_type next_polState;
    logic polarityLow;

    always_comb begin
        next_polState = polState;
        case (polState)
            gvfr_pkg::POL_WAIT: begin
                if (vEdge) next_polState = gvfr_pkg::POL_PART;
            end
            gvfr_pkg::POL_PART: begin
                if (vEdge) next_polState = gvfr_pkg::POL_ONE;
            end
            gvfr_pkg::POL_ONE: begin
                if (vEdge) next_polState = gvfr_pkg::POL_LOCK;
            end
            default: begin
                next_polState = gvfr_pkg::POL_LOCK;
            end
        endcase
        if (!genlockEn) next_polState = gvfr_pkg::POL_WAIT;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            polState <= gvfr_pkg::POL_WAIT;
        end else begin
            polState <= next_polState;
        end
    end

    // the active pulse is the shorter phase of the vertical reference
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            polarityLow <= gvfr_pkg::LEVEL_RST;
        end else if (vEdge && next_polState == gvfr_pkg::POL_LOCK) begin
            polarityLow <= next_lowLen < next_highLen;
        end
    end

    wire logic polLocked = genlockEn && polState == gvfr_pkg::POL_LOCK;
    wire logic leadNow = polLocked && (polarityLow ? vFall : vRise);

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vertRef <= gvfr_pkg::VERT_REF_RST;
        end else begin
            vertRef.vertLead <= leadNow;
            vertRef.polarityLow <= polarityLow;
            vertRef.polarityValid <= polLocked;
        end
    end

    // field level is sampled at the vertical leading edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lockRef <= gvfr_pkg::LOCK_REF_RST;
        end else begin
            lockRef.vertScanRef <= leadNow && presetModeEn;
            lockRef.fieldStart <= leadNow && presetModeEn && fieldPresent;
            if (!fieldPresent) begin
                lockRef.fieldValid <= 1'b0;
                lockRef.firstField <= 1'b0;
            end else if (leadNow) begin
                lockRef.fieldValid <= 1'b1;
                lockRef.firstField <= fieldConvBlanking ? ~fFilt : fFilt;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seqRiseLeadReady;
        genlockEn && polState == gvfr_pkg::POL_LOCK && !polarityLow && vRise;
    endsequence

    sequence seqFallLeadReady;
        genlockEn && polState == gvfr_pkg::POL_LOCK && polarityLow && vFall;
    endsequence

    sequence seqVertHeld;
        vertRefIn [*8] ##1 vertRefIn [*8];
    endsequence

    AST_LEAD_RISE: assert property (@(posedge clk) disable iff (sys_rst)
            seqRiseLeadReady |=> vertRef.vertLead)
        else $error("rising active edge gave no lead pulse");

    AST_LEAD_FALL: assert property (@(posedge clk) disable iff (sys_rst)
            seqFallLeadReady |=> vertRef.vertLead)
        else $error("falling active edge gave no lead pulse");

    AST_NO_LEAD_UNLOCKED: assert property (@(posedge clk) disable iff (sys_rst)
            vertRef.vertLead |-> $past(genlockEn) && $past(vEdge))
        else $error("lead pulse without genlock or without an edge");

    AST_FILTER_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
            $rose(vFilt) |-> $past(syncLevel[0], 1) && $past(syncLevel[0], 5))
        else $error("vertical level accepted before filter time");

    AST_SYNC_PASS: assert property (@(posedge clk) disable iff (sys_rst)
            seqVertHeld |-> vFilt)
        else $error("held vertical level did not pass synchroniser and filter");

    AST_SCAN_REF: assert property (@(posedge clk) disable iff (sys_rst)
            lockRef.vertScanRef == ($past(leadNow) && $past(presetModeEn)))
        else $error("vertical scanning reference mismatch");

    AST_FIELD_SYNC: assert property (@(posedge clk) disable iff (sys_rst)
            leadNow && fieldPresent && !fieldConvBlanking |=> lockRef.firstField == $past(fFilt))
        else $error("sync-based field decode wrong");

    AST_FIELD_BLANK: assert property (@(posedge clk) disable iff (sys_rst)
            leadNow && fieldPresent && fieldConvBlanking |=> lockRef.firstField != $past(fFilt))
        else $error("blanking-based field decode wrong");

    AST_FIELD_START: assert property (@(posedge clk) disable iff (sys_rst)
            lockRef.fieldStart |-> lockRef.vertScanRef && lockRef.fieldValid)
        else $error("field start without scan reference or valid field");

endmodule // gvfr_ref_input
`default_nettype wire

// >>> testbench/gvfr_ref_source.sv
// reference source model: vertical and field pins as a sync separator drives them
`timescale 1ns/1ns
`default_nettype none
module gvfr_ref_source (
    input wire logic clk,
    input wire logic run,
    input wire logic activeLow,
    input wire logic loose,
    input wire logic blanking,
    input wire logic hasField,
    input wire logic [7:0] activeLen,
    input wire logic [9:0] frameLen,
    output logic vertRefIn,
    output logic fieldReferenceIn,
    output logic leadMark,
    output logic firstMark
);
    logic [9:0] pos = 10'h000;
    logic firstNow = 1'b1;
    initial begin
        vertRefIn = 1'b0;
        fieldReferenceIn = 1'b0;
        leadMark = 1'b0;
        firstMark = 1'b0;
    end
    // ----------------------------------------
    // frame generator
    // ----------------------------------------
    always @(posedge clk) begin
        leadMark <= 1'b0;
        if (!run) begin
            pos <= 10'h000;
            vertRefIn <= activeLow;
            fieldReferenceIn <= 1'b0;
        end else begin
            pos <= (pos == frameLen - 10'h001) ? 10'h000 : pos + 10'h001;
            if (pos == 10'h000) begin
                vertRefIn <= ~activeLow;
                leadMark <= 1'b1;
                firstMark <= firstNow;
            end
            // analog-like bounce after the edge, then a runt far too short to count
            if (pos == 10'h002 && loose) vertRefIn <= activeLow;
            if (pos == 10'h003) vertRefIn <= ~activeLow;
            if (pos == {2'h0, activeLen}) vertRefIn <= activeLow;
            if (loose && pos == {2'h0, activeLen} + 10'h028) vertRefIn <= ~activeLow;
            if (loose && pos == {2'h0, activeLen} + 10'h02a) vertRefIn <= activeLow;
            // field level settles ahead of the lead so it is steady when sampled
            if (pos == frameLen - 10'h014) fieldReferenceIn <= hasField & (blanking ^ ~firstNow);
            if (pos == frameLen - 10'h001) firstNow <= ~firstNow;
        end
    end
endmodule // gvfr_ref_source
`default_nettype wire

// >>> testbench/gvfr_ref_input_tb_top.sv
// self-checking bench for the vertical and field reference input stage
`timescale 1ns/1ns
`default_nettype none
module gvfr_ref_input_tb_top;
    typedef struct packed {
        logic polLow;
        logic first;
        logic scan;
        logic fstart;
        logic fvalid;
        int stamp;
    } gvfr_note_type;
    logic clk = 1'b0, sysRst = 1'b1, genlockEn = 1'b0, presetModeEn = 1'b0;
    logic blanking = 1'b0, hasField = 1'b0, run = 1'b0, activeLow = 1'b0, loose = 1'b0;
    logic pushOn = 1'b0, monOn = 1'b0;
    logic [7:0] activeLen = 8'h20;
    logic [9:0] frameLen = 10'h100;
    logic vertRefIn, fieldReferenceIn, leadMark, firstMark;
    gvfr_pkg::gvfr_vert_ref_type vertRef;
    gvfr_pkg::gvfr_lock_ref_type lockRef;
    gvfr_note_type notes[$];
    gvfr_note_type nt;
    int errCount = 0, numChecks = 0, cyc = 0;
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    gvfr_ref_input gvfr_ref_input_i (.clk(clk), .sys_rst(sysRst), .vertRefIn(vertRefIn),
        .fieldReferenceIn(fieldReferenceIn), .genlockEn(genlockEn),
        .presetModeEn(presetModeEn), .fieldConvBlanking(blanking), .fieldPresent(hasField),
        .vertRef(vertRef), .lockRef(lockRef));
    gvfr_ref_source gvfr_ref_source_i (.clk(clk), .run(run), .activeLow(activeLow),
        .loose(loose), .blanking(blanking), .hasField(hasField), .activeLen(activeLen),
        .frameLen(frameLen), .vertRefIn(vertRefIn), .fieldReferenceIn(fieldReferenceIn),
        .leadMark(leadMark), .firstMark(firstMark));
    // ----------------------------------------
    // compare and verdict
    // ----------------------------------------
    task automatic chkBit(input string what, input logic exp, input logic got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chkWord(input string what, input logic [6:0] exp, input logic [6:0] got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // expectation notes and output monitor
    // ----------------------------------------
    always @(posedge clk) begin
        if (pushOn && leadMark)
            notes.push_back('{activeLow, firstMark, presetModeEn, presetModeEn & hasField,
                hasField, cyc});
    end
    always @(posedge clk) begin
        if (monOn && vertRef.vertLead === 1'b1) begin
            chkBit("lead expected", 1'b1, notes.size() != 0);
            if (notes.size() != 0) begin
                nt = notes.pop_front();
                chkBit("polarityLow", nt.polLow, vertRef.polarityLow);
                chkBit("polarityValid", 1'b1, vertRef.polarityValid);
                chkBit("vertScanRef", nt.scan, lockRef.vertScanRef);
                chkBit("fieldStart", nt.fstart, lockRef.fieldStart);
                chkBit("fieldValid", nt.fvalid, lockRef.fieldValid);
                chkBit("firstField", nt.fvalid & nt.first, lockRef.firstField);
                chkBit("lead latency", 1'b1, cyc - nt.stamp >= gvfr_pkg::SYNC_STAGES +
                    gvfr_pkg::FILTER_CYCLES && cyc - nt.stamp <= 30);
            end
        end else if (monOn) chkBit("stray vertScanRef", 1'b0, lockRef.vertScanRef);
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // polarity is relearnt per case, so the first frames are warm-up only
    task automatic runCase(input logic [2:0] i);
        genlockEn <= 1'b0;
        run <= 1'b0;
        repeat (40) @(posedge clk);
        chkBit("polarityValid off", 1'b0, vertRef.polarityValid);
        activeLow <= i[1];
        blanking <= i[0] ^ i[1] ^ i[2];
        hasField <= i[2];
        presetModeEn <= i[0] ^ i[2];
        loose <= i[0];
        activeLen <= 8'h14 + 8'($urandom_range(40));
        frameLen <= 10'h0c8 + 10'($urandom_range(200));
        @(posedge clk);
        genlockEn <= 1'b1;
        run <= 1'b1;
        repeat (4) @(posedge clk iff leadMark === 1'b1);
        repeat (30) @(posedge clk);
        pushOn <= 1'b1;
        monOn <= 1'b1;
        repeat (6) @(posedge clk iff leadMark === 1'b1);
        pushOn <= 1'b0;
        repeat (40) @(posedge clk);
        monOn <= 1'b0;
        chkBit("all leads seen", 1'b1, notes.size() == 0);
        notes.delete();
    endtask
    initial begin
        void'($urandom(32'hdf0f94e2));
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        for (int i = 0; i < 8; i++) runCase(3'(i));
        sysRst <= 1'b1;
        repeat (4) @(posedge clk);
        chkWord("outputs in reset", {gvfr_pkg::VERT_REF_RST, gvfr_pkg::LOCK_REF_RST},
            {vertRef, lockRef});
        sysRst <= 1'b0;
        runCase(3'h6);
        giveVerdict();
    end
    initial begin
        repeat (90000) @(posedge clk);
        errCount++;
        giveVerdict();
    end
endmodule // gvfr_ref_input_tb_top
`default_nettype wire
